// file: cmd_resp_crc_symbol_framer.sv
/*
 * Command checker, response builder and three-level symbol encoder for
 * the command/response exchange. Assumes command bits arrive already
 * decoded on core_clk, register bytes come back combinationally from
 * the register map, and the analog driver takes one level per chip.
 */
`timescale 1ns/1ns
`include "cmd_resp_framer_regs.svh"
module cmd_resp_crc_symbol_framer
    import cmd_resp_framer_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic [3:0]                 station_address_register,
    input  wire logic                       cmd_start,
    input  wire logic                       cmd_bit,
    input  wire logic                       cmd_bit_valid,
    output logic [6:0]                      register_even_index,
    input  wire logic [7:0]                 reg_even_data,
    input  wire logic [7:0]                 reg_odd_data,
    input  wire logic [7:0]                 chip_period,
    output cmd_resp_framer_pkg::chip_level_t chip_level,
    output logic                            chip_active,
    output logic                            resp_done,
    output logic                            cmd_accepted,
    output logic                            cmd_rejected
);
    import cmd_resp_framer_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Shared functions

    // One serial CRC step: bit enters the low end, top bit feeds back
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = {c[6:0], b} ^ (c[7] ? `CRF_CRC_POLY : `CRF_CRC_ZERO);
    endfunction

    // Nibble to chip triplet, first chip in the top two bits
    function automatic logic [5:0] symbol_of(input nibble_t n);
        case (n)
            4'h0:    symbol_of = {2'h1, 2'h1, 2'h0};
            4'h1:    symbol_of = {2'h2, 2'h1, 2'h1};
            4'h2:    symbol_of = {2'h1, 2'h0, 2'h2};
            4'h3:    symbol_of = {2'h2, 2'h0, 2'h2};
            4'h4:    symbol_of = {2'h1, 2'h0, 2'h0};
            4'h5:    symbol_of = {2'h2, 2'h1, 2'h2};
            4'h6:    symbol_of = {2'h1, 2'h1, 2'h2};
            4'h7:    symbol_of = {2'h2, 2'h0, 2'h1};
            4'h8:    symbol_of = {2'h2, 2'h2, 2'h0};
            4'h9:    symbol_of = {2'h2, 2'h1, 2'h0};
            4'ha:    symbol_of = {2'h1, 2'h2, 2'h2};
            4'hb:    symbol_of = {2'h2, 2'h2, 2'h1};
            4'hc:    symbol_of = {2'h1, 2'h2, 2'h0};
            4'hd:    symbol_of = {2'h2, 2'h0, 2'h0};
            4'he:    symbol_of = {2'h1, 2'h0, 2'h1};
            default: symbol_of = {2'h1, 2'h2, 2'h1};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Nibble FIFO between builder and encoder

    nibble_stream_if #(.WIDTH(4)) fill_bus ();   // Builder into FIFO
    nibble_stream_if #(.WIDTH(4)) drain_bus ();  // FIFO into encoder

    nibble_fifo #(
        .WIDTH (4),
        .DEPTH (16)
    ) u_fifo (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .fill_side  (fill_bus.sink),
        .drain_side (drain_bus.source)
    );

    ////////////////////////////////////////////////////////////////////
    // Command receiver state

    logic [7:0]  rx_crc;            // Serial checker register
    logic [31:0] rx_shift;          // Command bits, first one on top
    logic [5:0]  rx_count;          // Bits taken so far
    logic [7:0]  next_rx_crc;
    logic [31:0] next_rx_shift;
    logic [5:0]  next_rx_count;
    logic        next_cmd_accepted;
    logic        next_cmd_rejected;
    logic        busy;              // A response is still in flight

    // Check each bit as it arrives; verdict on the last CRC bit
    always_comb
    begin
        next_rx_crc       = rx_crc;
        next_rx_shift     = rx_shift;
        next_rx_count     = rx_count;
        next_cmd_accepted = 1'b0;
        next_cmd_rejected = 1'b0;
        if (cmd_start)
        begin
            next_rx_crc   = `CRF_CRC_SEED;
            next_rx_count = '0;
        end
        else if (cmd_bit_valid && rx_count != `CRF_CMD_BITS)
        begin
            next_rx_crc   = crc_step(rx_crc, cmd_bit);
            next_rx_shift = {rx_shift[30:0], cmd_bit};
            next_rx_count = rx_count + 6'h01;
            if (rx_count == `CRF_CMD_LAST)
            begin
                if (next_rx_crc != `CRF_CRC_ZERO)
                begin
                    next_cmd_rejected = 1'b1;
                end
                // Only a read to our own station, and only while idle
                else if (next_rx_shift[`CRF_CMD_ADDR_HI:`CRF_CMD_ADDR_LO]
                         == station_address_register
                         && next_rx_shift[`CRF_CMD_OP_HI:`CRF_CMD_OP_LO]
                         == `CRF_OP_READ
                         && !busy)
                begin
                    next_cmd_accepted = 1'b1;
                end
            end
        end
    end

    // Register receiver state
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_crc       <= `CRF_CRC_SEED;
            rx_shift     <= '0;
            rx_count     <= `CRF_CMD_BITS;       // No frame until cmd_start
            cmd_accepted <= 1'b0;
            cmd_rejected <= 1'b0;
        end
        else
        begin
            rx_crc       <= next_rx_crc;
            rx_shift     <= next_rx_shift;
            rx_count     <= next_rx_count;
            cmd_accepted <= next_cmd_accepted;
            cmd_rejected <= next_cmd_rejected;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Response builder state

    gen_state_t  gen_state;
    logic [23:0] gen_msg;           // Address, echo, odd byte, even byte
    logic [7:0]  gen_crc;           // Serial generator register
    logic [5:0]  gen_count;         // CRC steps or nibbles pushed
    logic [3:0]  gen_op;            // Opcode to echo
    gen_state_t  next_gen_state;
    logic [23:0] next_gen_msg;
    logic [7:0]  next_gen_crc;
    logic [5:0]  next_gen_count;
    logic [3:0]  next_gen_op;
    logic [6:0]  next_register_even_index;
    logic [31:0] resp_word;         // Full response with CRC last

    assign resp_word      = {gen_msg, gen_crc};
    assign fill_bus.valid = (gen_state == GEN_PUSH);
    assign fill_bus.data  = resp_word[31 - 4*gen_count[2:0] -: 4];

    // Capture, CRC over message plus eight zeros, then push nibbles
    always_comb
    begin
        next_gen_state           = gen_state;
        next_gen_msg             = gen_msg;
        next_gen_crc             = gen_crc;
        next_gen_count           = gen_count;
        next_gen_op              = gen_op;
        next_register_even_index = register_even_index;
        case (gen_state)
            GEN_IDLE:
            begin
                if (cmd_accepted)
                begin
                    next_register_even_index =
                        rx_shift[`CRF_CMD_IDX_HI:`CRF_CMD_IDX_LO];
                    next_gen_op    = rx_shift[`CRF_CMD_OP_HI:`CRF_CMD_OP_LO];
                    next_gen_state = GEN_CAPTURE;
                end
            end
            GEN_CAPTURE:
            begin
                // Index is stable for this cycle, so the map has answered
                next_gen_msg   = {station_address_register, gen_op,
                                  reg_odd_data, reg_even_data};
                next_gen_crc   = `CRF_CRC_SEED;
                next_gen_count = '0;
                next_gen_state = GEN_CRC;
            end
            GEN_CRC:
            begin
                // Message bits first, then zeros fill out the CRC length
                next_gen_crc = crc_step(gen_crc, (gen_count < `CRF_MSG_BITS)
                               ? gen_msg[5'd23 - gen_count[4:0]] : 1'b0);
                next_gen_count = gen_count + 6'h01;
                if (gen_count == `CRF_RESP_LAST)
                begin
                    next_gen_count = '0;
                    next_gen_state = GEN_PUSH;
                end
            end
            GEN_PUSH:
            begin
                // Waits on FIFO ready, so a stalled encoder holds us here
                if (fill_bus.ready)
                begin
                    next_gen_count = gen_count + 6'h01;
                    if (gen_count[2:0] == `CRF_NIBBLE_LAST)
                    begin
                        next_gen_state = GEN_IDLE;
                    end
                end
            end
            default:
            begin
                next_gen_state = GEN_IDLE;
            end
        endcase
    end

    // Register builder state
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gen_state           <= GEN_IDLE;
            gen_msg             <= '0;
            gen_crc             <= `CRF_CRC_SEED;
            gen_count           <= '0;
            gen_op              <= `CRF_OP_READ;
            register_even_index <= '0;
        end
        else
        begin
            gen_state           <= next_gen_state;
            gen_msg             <= next_gen_msg;
            gen_crc             <= next_gen_crc;
            gen_count           <= next_gen_count;
            gen_op              <= next_gen_op;
            register_even_index <= next_register_even_index;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Symbol encoder state

    enc_state_t  enc_state;
    logic [5:0]  enc_symbol;        // Chips left in this symbol, current one on top
    logic [1:0]  enc_chip;          // Chip index within symbol
    logic [7:0]  enc_timer;         // Cycles left in this chip
    logic [3:0]  enc_sent;          // Symbols started in this response
    enc_state_t  next_enc_state;
    logic [5:0]  next_enc_symbol;
    logic [1:0]  next_enc_chip;
    logic [7:0]  next_enc_timer;
    logic [3:0]  next_enc_sent;
    chip_level_t next_chip_level;
    logic        next_chip_active;
    logic        next_resp_done;
    logic [7:0]  period;            // Zero period treated as one cycle
    logic        chip_end;

    assign period   = (chip_period == '0) ? `CRF_TIMER_ONE : chip_period;
    assign chip_end = (enc_timer == `CRF_TIMER_ONE);
    assign busy     = (gen_state != GEN_IDLE) || (enc_state != ENC_IDLE)
                      || drain_bus.valid || cmd_accepted;

    // Pop a nibble and play its three chips, one per chip period
    always_comb
    begin
        next_enc_state   = enc_state;
        next_enc_symbol  = enc_symbol;
        next_enc_chip    = enc_chip;
        next_enc_timer   = enc_timer;
        next_enc_sent    = enc_sent;
        next_chip_level  = chip_level;
        next_chip_active = chip_active;
        next_resp_done   = 1'b0;
        drain_bus.ready  = 1'b0;
        case (enc_state)
            ENC_IDLE:
            begin
                if (drain_bus.valid)
                begin
                    drain_bus.ready = 1'b1;
                    next_enc_symbol = symbol_of(drain_bus.data);
                    next_chip_level = chip_level_t'(next_enc_symbol[5:4]);
                    next_enc_chip   = '0;
                    next_enc_timer  = period;
                    next_enc_sent   = enc_sent + 4'h1;
                    next_chip_active = 1'b1;
                    next_enc_state  = ENC_CHIP;
                end
            end
            ENC_CHIP:
            begin
                next_enc_timer = enc_timer - 8'h01;
                if (chip_end)
                begin
                    next_enc_timer = period;
                    if (enc_chip != `CRF_CHIP_LAST)
                    begin
                        next_enc_chip   = enc_chip + 2'h1;
                        next_enc_symbol = {enc_symbol[3:0], 2'h0};
                        next_chip_level = chip_level_t'(next_enc_symbol[5:4]);
                    end
                    else if (enc_sent == `CRF_NIBBLES)
                    begin
                        // Last CRC symbol ends the response
                        next_enc_sent    = '0;
                        next_chip_level  = quiescent_level;
                        next_chip_active = 1'b0;
                        next_resp_done   = 1'b1;
                        next_enc_state   = ENC_IDLE;
                    end
                    else if (drain_bus.valid)
                    begin
                        // Back to back keeps the chip stream seamless
                        drain_bus.ready = 1'b1;
                        next_enc_symbol = symbol_of(drain_bus.data);
                        next_chip_level = chip_level_t'(next_enc_symbol[5:4]);
                        next_enc_chip   = '0;
                        next_enc_sent   = enc_sent + 4'h1;
                    end
                    else
                    begin
                        // Underrun: fall quiet and wait for the next nibble
                        next_chip_level  = quiescent_level;
                        next_chip_active = 1'b0;
                        next_enc_state   = ENC_IDLE;
                    end
                end
            end
            default:
            begin
                next_enc_state = ENC_IDLE;
            end
        endcase
    end

    // Register encoder state and driver outputs
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enc_state   <= ENC_IDLE;
            enc_symbol  <= '0;
            enc_chip    <= '0;
            enc_timer   <= `CRF_TIMER_ONE;
            enc_sent    <= '0;
            chip_level  <= quiescent_level;
            chip_active <= 1'b0;
            resp_done   <= 1'b0;
        end
        else
        begin
            enc_state   <= next_enc_state;
            enc_symbol  <= next_enc_symbol;
            enc_chip    <= next_enc_chip;
            enc_timer   <= next_enc_timer;
            enc_sent    <= next_enc_sent;
            chip_level  <= next_chip_level;
            chip_active <= next_chip_active;
            resp_done   <= next_resp_done;
        end
    end
endmodule // cmd_resp_crc_symbol_framer

// file: cmd_resp_framer_regs.svh
/*
 * Named constants for the command/response framer: CRC seed and
 * polynomial, frame bit counts, field positions and opcode values.
 * Assumes it is included by bare name from package and design files.
 */
`ifndef CMD_RESP_FRAMER_REGS_SVH
`define CMD_RESP_FRAMER_REGS_SVH

// CRC engine
`define CRF_CRC_SEED      8'hff
`define CRF_CRC_POLY      8'h2f
`define CRF_CRC_ZERO      8'h00

// Frame lengths in bits, nibbles and chips
`define CRF_CMD_BITS      6'h20
`define CRF_CMD_LAST      6'h1f
`define CRF_MSG_BITS      6'h18
`define CRF_RESP_LAST     6'h1f
`define CRF_NIBBLES       4'h8
`define CRF_NIBBLE_LAST   3'h7
`define CRF_CHIP_LAST     2'h2

// Command field positions (bit 31 arrives first)
`define CRF_CMD_ADDR_HI   31
`define CRF_CMD_ADDR_LO   28
`define CRF_CMD_OP_HI     27
`define CRF_CMD_OP_LO     24
`define CRF_CMD_IDX_HI    23
`define CRF_CMD_IDX_LO    17

// Opcodes and timing
`define CRF_OP_READ       4'h0
`define CRF_TIMER_ONE     8'h01

`endif

// file: cmd_resp_framer_pkg.sv
/*
 * Types shared by the framer, its port checker and the self-checking bench.
 * Assumes the _regs header is on the include path.
 */
package cmd_resp_framer_pkg;
    `include "cmd_resp_framer_regs.svh"

    // Current level of one response chip
    typedef enum logic [1:0] {
        quiescent_level     = 2'h0,
        response_step_level = 2'h1,
        double_step_level   = 2'h2
    } chip_level_t;

    // Response generator states, Gray order along the usual path
    typedef enum logic [1:0] {
        GEN_IDLE    = 2'h0,
        GEN_CAPTURE = 2'h1,
        GEN_CRC     = 2'h3,
        GEN_PUSH    = 2'h2
    } gen_state_t;

    // Symbol encoder states
    typedef enum logic [1:0] {
        ENC_IDLE = 2'h0,
        ENC_CHIP = 2'h1
    } enc_state_t;

    typedef logic [3:0] nibble_t;
endpackage

// file: nibble_stream_if.sv
/*
 * Valid/ready stream carrying response nibbles between the framer and
 * its FIFO. Assumes both ends share one clock.
 */
`timescale 1ns/1ns
interface nibble_stream_if #(parameter int WIDTH = 4);
    logic             valid;  // Source holds a word
    logic             ready;  // Sink takes it this edge
    logic [WIDTH-1:0] data;   // Word itself

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// file: nibble_fifo.sv
/*
 * Synchronous FIFO with parameterised width and depth, valid/ready on
 * both sides. Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module nibble_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    nibble_stream_if.sink    fill_side,
    nibble_stream_if.source  drain_side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage array
    logic [AW-1:0]    wr_ptr;       // Next slot to write
    logic [AW-1:0]    rd_ptr;       // Next slot to read
    logic [AW:0]      fill;         // Words held
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_fill;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////
    // Honest full and empty: ready drops at full, valid at empty
    assign fill_side.ready  = (fill != (AW+1)'(DEPTH));
    assign drain_side.valid = (fill != '0);
    assign drain_side.data  = mem[rd_ptr];
    assign push = fill_side.valid && fill_side.ready;
    assign pop  = drain_side.valid && drain_side.ready;

    // Pointer and level arithmetic
    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_fill   = fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register pointers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill   <= next_fill;
        end
    end

    // Storage has no reset; contents are meaningless until written
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= fill_side.data;
        end
    end
endmodule // nibble_fifo

// file: cmd_resp_framer_checker.sv
/* Checker for the framer's top-level ports.
   Assumes one clock domain and the shared framer package. */
`timescale 1ns/1ns
module framer_checker
    import cmd_resp_framer_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  station_address_register,
    input wire logic        cmd_start,
    input wire logic        cmd_bit,
    input wire logic        cmd_bit_valid,
    input wire logic [6:0]  register_even_index,
    input wire logic [7:0]  reg_even_data,
    input wire logic [7:0]  reg_odd_data,
    input wire logic [7:0]  chip_period,
    input wire chip_level_t chip_level,
    input wire logic        chip_active,
    input wire logic        resp_done,
    input wire logic        cmd_accepted,
    input wire logic        cmd_rejected
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    a_verdict_single: assert property (cmd_accepted |-> !cmd_rejected ##1 !cmd_accepted)
        else $error("accept verdict not a lone pulse");
    a_reject_pulse: assert property (cmd_rejected |=> !cmd_rejected)
        else $error("reject verdict not a pulse");
    a_index_cause: assert property (!$stable(register_even_index) |-> $past(cmd_accepted))
        else $error("read index moved without an accepted read");
    a_accept_answers: assert property (cmd_accepted |-> ##[30:60] $rose(chip_active))
        else $error("accepted read got no response");
    a_idle_quiet: assert property (!chip_active |-> chip_level == quiescent_level)
        else $error("level driven outside a response");
    a_level_legal: assert property (chip_active |-> chip_level != 2'h3)
        else $error("illegal chip level");
    a_first_chip: assert property ($rose(chip_active) |-> chip_level != quiescent_level)
        else $error("response starts at quiescent level");
    a_done_after: assert property (resp_done |-> $past(chip_active)
        && !chip_active ##1 !resp_done)
        else $error("done pulse misplaced");
endmodule // framer_checker

bind cmd_resp_crc_symbol_framer framer_checker chk_u (.core_clk(core_clk), .reset_n(reset_n),
    .station_address_register(station_address_register), .cmd_start(cmd_start),
    .cmd_bit(cmd_bit), .cmd_bit_valid(cmd_bit_valid), .reg_even_data(reg_even_data),
    .register_even_index(register_even_index), .reg_odd_data(reg_odd_data),
    .chip_period(chip_period), .chip_level(chip_level), .chip_active(chip_active),
    .resp_done(resp_done), .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected));

// file: cmd_master_model.sv
/* Bus master model: frames 32-bit commands bit-serially with CRC.
   Assumes the framer samples on the rising edge of core_clk. */
`timescale 1ns/1ns
module cmd_master_model (
    input  wire logic core_clk,
    output logic      cmd_start,
    output logic      cmd_bit,
    output logic      cmd_bit_valid
);
    initial {cmd_start, cmd_bit, cmd_bit_valid} = 3'h0;
    // Serial CRC, seed all ones, eight zeros appended after the message
    function automatic logic [7:0] crc24(input logic [23:0] m);
        logic [7:0]  c;
        logic [31:0] s;
        c = 8'hff;
        s = {m, 8'h00};
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], s[i]} ^ (c[7] ? 8'h2f : 8'h00);
        return c;
    endfunction
    // Send a frame; bad flips the check bit, gap idles between bits
    task automatic send(input logic [23:0] m, input logic bad, input int gap);
        logic [31:0] f;
        f = {m, crc24(m) ^ {7'h00, bad}};
        @(negedge core_clk) cmd_start = 1'b1;
        @(negedge core_clk) cmd_start = 1'b0;
        cmd_bit_valid = 1'b1;
        for (int i = 31; i >= 0; i--)
        begin
            cmd_bit = f[i];
            @(negedge core_clk);
            if (gap > 0 && i > 0)
            begin
                cmd_bit_valid = 1'b0;
                repeat (gap) @(negedge core_clk);
                cmd_bit_valid = 1'b1;
            end
        end
        cmd_bit_valid = 1'b0;
        cmd_bit = ~cmd_bit; // Never leave a stale bit that looks valid
    endtask
endmodule // cmd_master_model

// file: cmd_resp_crc_symbol_framer_test.sv
/* Self-checking bench: reads, bad CRC, foreign address, unread opcode.
   Assumes the master model and the framer package. */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cmd_resp_crc_symbol_framer_test;
    import cmd_resp_framer_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  station = 4'h5;
    logic [7:0]  even_data = 8'h00, odd_data = 8'h00, period = 8'h01;
    logic [6:0]  index;
    chip_level_t level;
    logic        active, done, accepted, rejected, c_start, c_bit, c_valid;
    int          err_total = 0, num_checks = 0, cycles = 0;
    // Chip triplets for nibbles 0..F, two bits a chip, first chip on top
    localparam logic [5:0] SYM [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26,
        6'h16, 6'h21, 6'h28, 6'h24, 6'h1a, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
    always #25 core_clk = ~core_clk;
    cmd_master_model m_u (.core_clk(core_clk), .cmd_start(c_start), .cmd_bit(c_bit),
        .cmd_bit_valid(c_valid));
    cmd_resp_crc_symbol_framer dut_u (.core_clk(core_clk), .reset_n(reset_n),
        .station_address_register(station), .cmd_start(c_start), .cmd_bit(c_bit),
        .cmd_bit_valid(c_valid), .register_even_index(index), .reg_even_data(even_data),
        .reg_odd_data(odd_data), .chip_period(period), .chip_level(level),
        .chip_active(active), .resp_done(done), .cmd_accepted(accepted),
        .cmd_rejected(rejected));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, far above the roughly one thousand cycles the run needs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            err_total++;
            summarize();
        end
    end
    // Wait a bounded time for a verdict pulse, then compare both flags
    task automatic verdict(input logic acc, input logic rej);
        int n;
        n = 0;
        while (!(accepted === 1'b1 || rejected === 1'b1) && n < 3)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK({accepted, rejected}, {acc, rej})
    endtask
    // A dropped command must leave the current output idle
    task automatic stay_quiet();
        logic saw;
        saw = 1'b0;
        repeat (80) @(negedge core_clk) saw = saw | active;
        `CHK(saw, 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic crc_case();
        `CHK(m_u.crc24(24'h410101), 8'hd4)
        `CHK(m_u.crc24(24'h181186), 8'hb0)
    endtask
    // Read, then decode all 24 chips against the expected response
    task automatic read_case(input logic [3:0] s, input logic [7:0] odd, even,
        input logic [6:0] idx, input logic [7:0] p, input int gap);
        logic [31:0] r;
        int          k;
        station = s;
        odd_data = odd;
        even_data = even;
        period = p;
        r = {s, 4'h0, odd, even, m_u.crc24({s, 4'h0, odd, even})};
        m_u.send({s, 4'h0, idx, 1'b0, 8'h00}, 1'b0, gap);
        verdict(1'b1, 1'b0);
        @(negedge core_clk);
        `CHK(index, idx)
        k = 0;
        while (active !== 1'b1 && k < 100)
        begin
            @(negedge core_clk);
            k++;
        end
        for (k = 0; k < 24; k++)
        begin
            `CHK(level, SYM[r[31-4*(k/3) -: 4]][5-2*(k%3) -: 2])
            repeat (p == 8'h00 ? 1 : p) @(negedge core_clk);
        end
        `CHK({done, active, level}, {1'b1, 1'b0, 2'h0})
    endtask
    // A second read landing while the first is still answering is dropped
    task automatic busy_case();
        int k;
        m_u.send({station, 4'h0, 16'h0400}, 1'b0, 0);
        verdict(1'b1, 1'b0);
        m_u.send({station, 4'h0, 16'h0800}, 1'b0, 0);
        verdict(1'b0, 1'b0);
        for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge core_clk);
        `CHK({done, index}, {1'b1, 7'h02})
        stay_quiet();
    endtask
    task automatic bad_crc_case();
        m_u.send({station, 4'h0, 16'h0400}, 1'b1, 0);
        verdict(1'b0, 1'b1);
        stay_quiet();
    endtask
    task automatic foreign_addr_case();
        m_u.send({station ^ 4'h1, 4'h0, 16'h0400}, 1'b0, 0);
        verdict(1'b0, 1'b0);
        stay_quiet();
    endtask
    task automatic write_op_case();
        m_u.send({station, 4'h8, 16'h0412}, 1'b0, 0);
        verdict(1'b0, 1'b0);
        stay_quiet();
    endtask
    initial
    begin
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        crc_case();
        read_case(4'h5, 8'h01, 8'h23, 7'h00, 8'h00, 0);
        read_case(4'hf, 8'h45, 8'h67, 7'h7f, 8'h01, 1);
        read_case(4'h1, 8'h89, 8'hab, 7'h2a, 8'h03, 0);
        read_case(4'ha, 8'hcd, 8'hef, 7'h55, 8'h02, 2);
        busy_case();
        bad_crc_case();
        foreign_addr_case();
        write_op_case();
        summarize();
    end
endmodule // cmd_resp_crc_symbol_framer_test
